//--- rtl/cas_supervisor.sv
// channel alarm supervisor: thresholds, latching, relay and bus-line routing, speed routing
// assumes synchronous inputs, one clock, a plain register port with read data one cycle later
// Notes on behaviour
// - four settable thresholds per channel
// - relay driven by one or combined alarms
// - bypass input silences trip-linked relays
// - multiply input raises the two high levels of selected channels
// - clear input clears latched alarms whose condition is absent in the clear cycle
// - inhibited channel cannot actuate relays
// - eight-channel build lacks multiply input
// - safety build ignores bypass, multiply, inhibit
// - alarms routable to backplane and raw lines
// - two speed inputs routable onto speed bus
// - active routed alarm drives line control high
`timescale 1ns/1ns
`default_nettype none
`include "cas_defines.svh"
module cas_supervisor #(
  parameter cas_pkg::cas_variant_t VARIANT = cas_pkg::CAS_VAR_FOUR
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic [`CAS_AW-1:0]        reg_addr_i,
  input  wire logic [`CAS_DW-1:0]        reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [`CAS_DW-1:0]             reg_rdata_o,
  input  wire cas_pkg::cas_meas_t        meas_i,
  input  wire logic [`CAS_NUM_SPD-1:0]   speed_i,
  input  wire logic                      trip_level_bypass_i,
  input  wire logic                      level_multiply_input_i,
  input  wire logic                      latch_clear_input_i,
  output logic [`CAS_NUM_RLY-1:0]        relay_o,
  output logic [`CAS_NUM_OCL-1:0]        backplane_alarm_lines_o,
  output logic [`CAS_NUM_RAW-1:0]        raw_line_o,
  output logic [`CAS_NUM_TB-1:0]         speed_bus_o,
  output logic [`CAS_NUM_TB-1:0]         speed_bus_oe_o,
  output logic                           irq_o
);
  import cas_pkg::*;

  localparam logic [`CAS_NUM_COND-1:0] COND_EN =
    (VARIANT == CAS_VAR_FOUR) ? `CAS_FOUR_MASK : {`CAS_NUM_COND{1'b1}};
  localparam logic HAS_BYP  = (VARIANT != CAS_VAR_SAFE);
  localparam logic HAS_MULT = (VARIANT == CAS_VAR_FOUR);
  localparam logic HAS_INH  = (VARIANT != CAS_VAR_SAFE);

  function automatic cas_state_t rst_val();
    cas_state_t s;
    s = '0;
    for (int c = 0; c < `CAS_NUM_CH; c++) begin
      s.thr[c][`CAS_LVL_WLO] = `CAS_THR_LO_RST;
      s.thr[c][`CAS_LVL_TLO] = `CAS_THR_LO_RST;
      s.thr[c][`CAS_LVL_WHI] = `CAS_THR_HI_RST;
      s.thr[c][`CAS_LVL_THI] = `CAS_THR_HI_RST;
    end
    s.mult_fact = `CAS_MFACT_RST;
    return s;
  endfunction : rst_val

  function automatic logic [`CAS_NUM_COND-1:0] per_ch(input logic [`CAS_NUM_CH-1:0] m);
    logic [`CAS_NUM_COND-1:0] r;
    r = '0;
    for (int c = 0; c < `CAS_NUM_CH; c++) begin
      r[c*`CAS_NUM_LVL +: `CAS_NUM_LVL] = {`CAS_NUM_LVL{m[c]}};
    end
    return r;
  endfunction : per_ch

  cas_state_t                 q;
  cas_state_t                 d;
  logic [`CAS_NUM_COND-1:0]   hit_w;
  logic [`CAS_NUM_COND-1:0]   act_w;
  logic [`CAS_NUM_COND-1:0]   eff_w;
  logic [`CAS_NUM_COND-1:0]   lmask_w;
  logic [`CAS_NUM_COND-1:0]   sel_w;
  logic [`CAS_NUM_COND-1:0]   rise_w;
  logic [`CAS_NUM_CH-1:0]     inh_w;
  logic [`CAS_NUM_EV-1:0]     ev_w;
  logic                       byp_w;
  logic                       mul_w;
  logic                       clr_w;
  logic                       on_w;
  logic                       thr_hit;
  logic                       rly_hit;
  logic                       ocl_hit;
  logic                       raw_hit;

  // one comparator per channel
  for (genvar c = 0; c < `CAS_NUM_CH; c++) begin : g_ch
    cas_level_cmp u_cmp (
      .mult_i   (mul_w & q.mult_sel[c]),
      .factor_i (q.mult_fact),
      .value_i  (meas_i[c]),
      .thr_i    (q.thr[c]),
      .hit_o    (hit_w[c*`CAS_NUM_LVL +: `CAS_NUM_LVL])
    );
  end

  always_comb begin
    d       = q;
    d.rdata = '0;
    thr_hit = (reg_addr_i & ~`CAS_THR_SPAN) == `CAS_THR_BASE;
    rly_hit = (reg_addr_i & ~`CAS_RLY_SPAN) == `CAS_RLY_BASE;
    ocl_hit = (reg_addr_i & ~`CAS_OCL_SPAN) == `CAS_OCL_BASE;
    raw_hit = (reg_addr_i & ~`CAS_RAW_SPAN) == `CAS_RAW_BASE;
    byp_w   = HAS_BYP & trip_level_bypass_i;
    mul_w   = HAS_MULT & level_multiply_input_i;
    inh_w   = HAS_INH ? q.inhibit : '0;
    clr_w   = latch_clear_input_i |
              (reg_wr_i && reg_addr_i == `CAS_REG_CTRL && reg_wdata_i[`CAS_CTRL_CLR]);
    // alarm conditions and latches; a condition present in the clear cycle survives
    d.cond  = hit_w & COND_EN;
    lmask_w = {`CAS_NUM_CH{q.latch_en}};
    d.held  = lmask_w & (q.cond | (q.held & ~{`CAS_NUM_COND{clr_w}}));
    act_w   = q.cond | q.held;
    eff_w   = act_w & ~per_ch(inh_w);
    // relays: OR of selected alarms, or AND when the relay is in combine mode
    sel_w   = '0;
    on_w    = 1'b0;
    for (int r = 0; r < `CAS_NUM_RLY; r++) begin
      sel_w = q.rly_mask[r];
      on_w  = q.rly_and[r] ? (sel_w != '0 && (eff_w & sel_w) == sel_w)
                           : |(eff_w & sel_w);
      if (byp_w && |(sel_w & `CAS_TRIP_MASK)) begin
        on_w = 1'b0;
      end
      d.rly_out[r] = on_w;
    end
    // bus lines feed relays on the relay card, so bypass applies there too
    for (int l = 0; l < `CAS_NUM_OCL; l++) begin
      d.ocl_out[l] = |(eff_w & q.ocl_mask[l]) &&
                     !(byp_w && |(q.ocl_mask[l] & `CAS_TRIP_MASK));
    end
    for (int l = 0; l < `CAS_NUM_RAW; l++) begin
      d.raw_out[l] = |(eff_w & q.raw_mask[l]) &&
                     !(byp_w && |(q.raw_mask[l] & `CAS_TRIP_MASK));
    end
    // speed routing; two inputs on one line are ORed, software should avoid it
    d.spd_bus = '0;
    d.spd_oe  = '0;
    for (int s = 0; s < `CAS_NUM_SPD; s++) begin
      if (q.speed_cfg[s*4 + `CAS_SPD_EN]) begin
        d.spd_bus[q.speed_cfg[s*4 +: 3]] = d.spd_bus[q.speed_cfg[s*4 +: 3]] | speed_i[s];
        d.spd_oe[q.speed_cfg[s*4 +: 3]]  = 1'b1;
      end
    end
    // events: new condition per level kind, and a clear; set wins over read-clear
    rise_w = d.cond & ~q.cond;
    ev_w   = '0;
    for (int c = 0; c < `CAS_NUM_CH; c++) begin
      ev_w[`CAS_NUM_LVL-1:0] = ev_w[`CAS_NUM_LVL-1:0] | rise_w[c*`CAS_NUM_LVL +: `CAS_NUM_LVL];
    end
    ev_w[`CAS_NUM_LVL] = clr_w;
    d.int_stat = ((reg_rd_i && reg_addr_i == `CAS_REG_ISTAT) ? '0 : q.int_stat) | ev_w;
    // register writes
    if (reg_wr_i) begin
      if (thr_hit) begin
        d.thr[reg_addr_i[4:2]][reg_addr_i[1:0]] = reg_wdata_i[`CAS_VW-1:0];
      end else if (rly_hit) begin
        d.rly_mask[reg_addr_i[2:0]] = reg_wdata_i;
      end else if (ocl_hit) begin
        d.ocl_mask[reg_addr_i[3:0]] = reg_wdata_i;
      end else if (raw_hit) begin
        d.raw_mask[reg_addr_i[1:0]] = reg_wdata_i;
      end else begin
        unique case (reg_addr_i)
          `CAS_REG_INHIB:  d.inhibit   = reg_wdata_i[`CAS_NUM_CH-1:0];
          `CAS_REG_MSEL:   d.mult_sel  = reg_wdata_i[`CAS_NUM_CH-1:0];
          `CAS_REG_MFACT:  d.mult_fact = reg_wdata_i[7:0];
          `CAS_REG_SPEED:  d.speed_cfg = reg_wdata_i[4*`CAS_NUM_SPD-1:0];
          `CAS_REG_IMASK:  d.int_mask  = reg_wdata_i[`CAS_NUM_EV-1:0];
          `CAS_REG_RLYAND: d.rly_and   = reg_wdata_i[`CAS_NUM_RLY-1:0];
          `CAS_REG_LATEN:  d.latch_en  = reg_wdata_i[`CAS_NUM_LVL-1:0];
          default: ;
        endcase
      end
    end
    // register reads; unmapped offsets answer zero
    if (reg_rd_i) begin
      if (thr_hit) begin
        d.rdata[`CAS_VW-1:0] = q.thr[reg_addr_i[4:2]][reg_addr_i[1:0]];
      end else if (rly_hit) begin
        d.rdata = q.rly_mask[reg_addr_i[2:0]];
      end else if (ocl_hit) begin
        d.rdata = q.ocl_mask[reg_addr_i[3:0]];
      end else if (raw_hit) begin
        d.rdata = q.raw_mask[reg_addr_i[1:0]];
      end else begin
        unique case (reg_addr_i)
          `CAS_REG_INHIB:  d.rdata[`CAS_NUM_CH-1:0]    = q.inhibit;
          `CAS_REG_MSEL:   d.rdata[`CAS_NUM_CH-1:0]    = q.mult_sel;
          `CAS_REG_MFACT:  d.rdata[7:0]                = q.mult_fact;
          `CAS_REG_SPEED:  d.rdata[4*`CAS_NUM_SPD-1:0] = q.speed_cfg;
          `CAS_REG_ALARM:  d.rdata                     = act_w;
          `CAS_REG_ISTAT:  d.rdata[`CAS_NUM_EV-1:0]    = q.int_stat;
          `CAS_REG_IMASK:  d.rdata[`CAS_NUM_EV-1:0]    = q.int_mask;
          `CAS_REG_RLYAND: d.rdata[`CAS_NUM_RLY-1:0]   = q.rly_and;
          `CAS_REG_LATEN:  d.rdata[`CAS_NUM_LVL-1:0]   = q.latch_en;
          `CAS_REG_LIVE:   d.rdata                     = q.cond;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= rst_val();
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o             = q.rdata;
  assign relay_o                 = q.rly_out;
  assign backplane_alarm_lines_o = q.ocl_out;
  assign raw_line_o              = q.raw_out;
  assign speed_bus_o             = q.spd_bus;
  assign speed_bus_oe_o          = q.spd_oe;
  assign irq_o                   = |(q.int_stat & q.int_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_thr_wr;
    reg_wr_i && thr_hit |=> q.thr[$past(reg_addr_i[4:2])][$past(reg_addr_i[1:0])] == $past(reg_wdata_i[15:0]);
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost");

  property p_rly_or;
    !q.rly_and[0] && |(eff_w & q.rly_mask[0]) && !byp_w ##1 !reset_i |-> relay_o[0];
  endproperty
  a_rly_or: assert property (p_rly_or) else $error("relay 0 not driven by alarm");

  property p_bypass;
    byp_w && |(q.rly_mask[0] & `CAS_TRIP_MASK) |=> !relay_o[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("trip relay active under bypass");

  property p_clear;
    latch_clear_input_i |=> (q.held & ~$past(q.cond)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("latched alarm survived clear");

  property p_inhibit;
    HAS_INH && q.inhibit[0] |-> eff_w[`CAS_NUM_LVL-1:0] == '0;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited channel still active");

  property p_no_mult;
    !HAS_MULT |-> !mul_w;
  endproperty
  a_no_mult: assert property (p_no_mult) else $error("multiply active in variant without it");

  property p_safe;
    (VARIANT == CAS_VAR_SAFE) |-> (eff_w == act_w) && !byp_w && !mul_w;
  endproperty
  a_safe: assert property (p_safe) else $error("safety build honoured a control");

  property p_line;
    |(eff_w & q.ocl_mask[0]) && !byp_w |=> backplane_alarm_lines_o[0];
  endproperty
  a_line: assert property (p_line) else $error("backplane line not driven");

  property p_speed;
    q.speed_cfg[`CAS_SPD_EN] && speed_i[0] |=> speed_bus_oe_o[$past(q.speed_cfg[2:0])] && speed_bus_o[$past(q.speed_cfg[2:0])];
  endproperty
  a_speed: assert property (p_speed) else $error("speed 0 not on bus line");

  property p_hold;
    !clr_w |=> ($past(q.held & lmask_w) & ~q.held) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("latched alarm dropped without clear");
endmodule : cas_supervisor
`default_nettype wire

//--- inc/cas_defines.svh
// constants of the channel alarm supervisor: sizes, register offsets, fields, resets
// assumes inclusion by bare name from the package and the design files
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH
`define CAS_NUM_CH     8
`define CAS_NUM_LVL    4
`define CAS_NUM_COND   32
`define CAS_NUM_RLY    8
`define CAS_NUM_OCL    16
`define CAS_NUM_RAW    4
`define CAS_NUM_SPD    2
`define CAS_NUM_TB     8
`define CAS_VW         16
`define CAS_AW         7
`define CAS_DW         32
`define CAS_NUM_EV     5
`define CAS_LVL_WLO    0
`define CAS_LVL_WHI    1
`define CAS_LVL_TLO    2
`define CAS_LVL_THI    3
`define CAS_TRIP_MASK  32'hCCCCCCCC
`define CAS_FOUR_MASK  32'h0000FFFF
`define CAS_REG_CTRL   7'h00
`define CAS_REG_INHIB  7'h01
`define CAS_REG_MSEL   7'h02
`define CAS_REG_MFACT  7'h03
`define CAS_REG_SPEED  7'h04
`define CAS_REG_ALARM  7'h05
`define CAS_REG_ISTAT  7'h06
`define CAS_REG_IMASK  7'h07
`define CAS_REG_RLYAND 7'h08
`define CAS_REG_LATEN  7'h09
`define CAS_REG_LIVE   7'h0A
`define CAS_THR_BASE   7'h20
`define CAS_THR_SPAN   7'h1F
`define CAS_RLY_BASE   7'h40
`define CAS_RLY_SPAN   7'h07
`define CAS_OCL_BASE   7'h50
`define CAS_OCL_SPAN   7'h0F
`define CAS_RAW_BASE   7'h60
`define CAS_RAW_SPAN   7'h03
`define CAS_CTRL_CLR   0
`define CAS_SPD_EN     3
`define CAS_MFACT_RST  8'h10
`define CAS_THR_LO_RST 16'h0000
`define CAS_THR_HI_RST 16'hFFFF
`endif

//--- inc/cas_pkg.sv
// types of the channel alarm supervisor
// assumes cas_defines.svh on the include path
`include "cas_defines.svh"
package cas_pkg;
  typedef enum logic [1:0] {
    CAS_VAR_FOUR  = 2'h0,
    CAS_VAR_EIGHT = 2'h1,
    CAS_VAR_SAFE  = 2'h3
  } cas_variant_t;
  typedef logic [`CAS_VW-1:0]                     cas_val_t;
  typedef cas_val_t [`CAS_NUM_LVL-1:0]            cas_lvl_t;
  typedef cas_val_t [`CAS_NUM_CH-1:0]             cas_meas_t;
  typedef struct packed {
    cas_lvl_t [`CAS_NUM_CH-1:0]                   thr;
    logic [`CAS_NUM_RLY-1:0][`CAS_NUM_COND-1:0]   rly_mask;
    logic [`CAS_NUM_OCL-1:0][`CAS_NUM_COND-1:0]   ocl_mask;
    logic [`CAS_NUM_RAW-1:0][`CAS_NUM_COND-1:0]   raw_mask;
    logic [`CAS_NUM_CH-1:0]                       inhibit;
    logic [`CAS_NUM_CH-1:0]                       mult_sel;
    logic [7:0]                                   mult_fact;
    logic [`CAS_NUM_RLY-1:0]                      rly_and;
    logic [4*`CAS_NUM_SPD-1:0]                    speed_cfg;
    logic [`CAS_NUM_LVL-1:0]                      latch_en;
    logic [`CAS_NUM_COND-1:0]                     cond;
    logic [`CAS_NUM_COND-1:0]                     held;
    logic [`CAS_NUM_EV-1:0]                       int_stat;
    logic [`CAS_NUM_EV-1:0]                       int_mask;
    logic [`CAS_DW-1:0]                           rdata;
    logic [`CAS_NUM_RLY-1:0]                      rly_out;
    logic [`CAS_NUM_OCL-1:0]                      ocl_out;
    logic [`CAS_NUM_RAW-1:0]                      raw_out;
    logic [`CAS_NUM_TB-1:0]                       spd_bus;
    logic [`CAS_NUM_TB-1:0]                       spd_oe;
  } cas_state_t;
endpackage : cas_pkg

//--- rtl/cas_level_cmp.sv
// four-level threshold comparator for one measurement channel
// assumes thresholds and factor stable from registers; purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "cas_defines.svh"
module cas_level_cmp (
  input  wire logic              mult_i,
  input  wire logic [7:0]        factor_i,
  input  wire cas_pkg::cas_val_t value_i,
  input  wire cas_pkg::cas_lvl_t thr_i,
  output logic [`CAS_NUM_LVL-1:0] hit_o
);
  import cas_pkg::*;
  logic [23:0] prod_wh;
  logic [23:0] prod_th;
  logic [19:0] lim_wh;
  logic [19:0] lim_th;
  // factor is 4.4 fixed point; 20-bit limit so a raised level never wraps
  always_comb begin
    prod_wh = {8'h00, thr_i[`CAS_LVL_WHI]} * {16'h0000, factor_i};
    prod_th = {8'h00, thr_i[`CAS_LVL_THI]} * {16'h0000, factor_i};
    lim_wh  = mult_i ? prod_wh[23:4] : {4'h0, thr_i[`CAS_LVL_WHI]};
    lim_th  = mult_i ? prod_th[23:4] : {4'h0, thr_i[`CAS_LVL_THI]};
    hit_o[`CAS_LVL_WLO] = value_i < thr_i[`CAS_LVL_WLO];
    hit_o[`CAS_LVL_TLO] = value_i < thr_i[`CAS_LVL_TLO];
    hit_o[`CAS_LVL_WHI] = {4'h0, value_i} > lim_wh;
    hit_o[`CAS_LVL_THI] = {4'h0, value_i} > lim_th;
  end
endmodule : cas_level_cmp
`default_nettype wire

//--- tb/cas_relay_card_model.sv
// relay card model: open-collector backplane lines and raw pairs feeding relay coils
// assumes driver controls straight from the supervisor outputs, pull-up on each card line
`timescale 1ns/1ns
`default_nettype none
`include "cas_defines.svh"
module cas_relay_card_model (
  input  wire logic [`CAS_NUM_OCL-1:0]             drive_i,
  input  wire logic [`CAS_NUM_RAW-1:0]             raw_i,
  output logic [`CAS_NUM_OCL-1:0]                  line_o,
  output logic [`CAS_NUM_RAW+`CAS_NUM_OCL-1:0]     coil_o
);
  // high control pulls the line to ground, otherwise the pull-up wins
  assign line_o = ~drive_i;
  // a coil energises on a pulled line or an active raw line
  assign coil_o = {raw_i, ~line_o};
endmodule : cas_relay_card_model
`default_nettype wire

//--- tb/test_channel_alarm_supervisor.sv
// self-checking bench of the supervisor, four-channel build, driven over its register port
// assumes cas_pkg, cas_defines.svh and the relay card model compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "cas_defines.svh"
module test_channel_alarm_supervisor;
  import cas_pkg::*;
  logic                    clk_i;
  logic                    reset_i;
  logic [`CAS_AW-1:0]      reg_addr_i;
  logic [`CAS_DW-1:0]      reg_wdata_i;
  logic                    reg_wr_i;
  logic                    reg_rd_i;
  logic [`CAS_DW-1:0]      reg_rdata_o;
  cas_meas_t               meas_i;
  logic [`CAS_NUM_SPD-1:0] speed_i;
  logic                    bypass;
  logic                    mult;
  logic                    clr;
  logic [`CAS_NUM_RLY-1:0] relay_o;
  logic [`CAS_NUM_OCL-1:0] ocl;
  logic [`CAS_NUM_RAW-1:0] raw;
  logic [`CAS_NUM_TB-1:0]  spd_bus;
  logic [`CAS_NUM_TB-1:0]  spd_oe;
  logic                    irq_o;
  logic [`CAS_NUM_OCL-1:0] line;
  logic [19:0]             coil;
  logic [`CAS_DW-1:0]      rd_val;
  int                      bad_count;
  int                      samples_checked;
  logic [15:0]             lvl_val [4];
  logic [31:0]             lvl_exp [4];

  cas_supervisor #(.VARIANT(CAS_VAR_FOUR)) i_dut (
    .clk_i                  (clk_i),
    .reset_i                (reset_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_wr_i               (reg_wr_i),
    .reg_rd_i               (reg_rd_i),
    .reg_rdata_o            (reg_rdata_o),
    .meas_i                 (meas_i),
    .speed_i                (speed_i),
    .trip_level_bypass_i    (bypass),
    .level_multiply_input_i (mult),
    .latch_clear_input_i    (clr),
    .relay_o                (relay_o),
    .backplane_alarm_lines_o(ocl),
    .raw_line_o             (raw),
    .speed_bus_o            (spd_bus),
    .speed_bus_oe_o         (spd_oe),
    .irq_o                  (irq_o)
  );

  cas_relay_card_model i_card (.drive_i(ocl), .raw_i(raw), .line_o(line), .coil_o(coil));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge, zero after that
  task rd(input logic [6:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    @(posedge clk_i);
    #1 chk(reg_rdata_o, 32'h0);
  endtask : rd

  // two cycles from value to relay, one spare
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task meas0(input logic [15:0] v);
    @(posedge clk_i);
    meas_i[0] <= v;
    settle();
  endtask : meas0

  task outs(input logic [7:0] r, input logic [19:0] c);
    chk({24'h0, relay_o}, {24'h0, r});
    chk({12'h0, coil}, {12'h0, c});
  endtask : outs

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end

  initial begin
    reset_i = 1'b1; reg_addr_i = 7'h00; reg_wdata_i = 32'h0; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    meas_i = '0; speed_i = 2'h0; bypass = 1'b0; mult = 1'b0; clr = 1'b0;
    bad_count = 0; samples_checked = 0;
    lvl_val = '{16'h00C0, 16'h0040, 16'h0850, 16'h0A00};
    lvl_exp = '{32'h10, 32'h50, 32'h20, 32'hA0};
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(7'h03, 32'h10);
    rd(7'h21, 32'hFFFF);
    rd(7'h7F, 32'h0);
    outs(8'h00, 20'h0);
    // every level kind of one channel, low and high sides
    wr(7'h24, 32'h0100); wr(7'h25, 32'h0800); wr(7'h26, 32'h0080); wr(7'h27, 32'h0900);
    wr(7'h07, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      meas_i[1] <= lvl_val[i];
      settle();
      rd(7'h05, lvl_exp[i]);
    end
    @(posedge clk_i);
    meas_i[1] <= 16'h0400;
    rd(7'h06, 32'h0F);
    // ch0 routing: r0 warn high, r1 trip high, r2 both in and-mode
    wr(7'h21, 32'h0100); wr(7'h23, 32'h0300);
    wr(7'h40, 32'h2); wr(7'h41, 32'h8); wr(7'h42, 32'hA); wr(7'h08, 32'h4);
    wr(7'h50, 32'h2); wr(7'h60, 32'h8);
    meas0(16'h0200);
    outs(8'h01, 20'h00001);
    chk({31'h0, irq_o}, 32'h1);
    rd(7'h06, 32'h02);
    chk({31'h0, irq_o}, 32'h0);
    wr(7'h01, 32'h1);
    settle();
    outs(8'h00, 20'h0);
    rd(7'h05, 32'h2);
    wr(7'h01, 32'h0);
    meas0(16'h0400);
    outs(8'h07, 20'h10001);
    @(posedge clk_i);
    bypass <= 1'b1;
    settle();
    outs(8'h01, 20'h00001);
    @(posedge clk_i);
    bypass <= 1'b0;
    // factor 2.0 in 4.4: limits 0x200 and 0x600
    wr(7'h02, 32'h1); wr(7'h03, 32'h20);
    @(posedge clk_i);
    mult <= 1'b1;
    settle();
    outs(8'h01, 20'h00001);
    wr(7'h09, 32'h8);
    @(posedge clk_i);
    mult <= 1'b0;
    settle();
    outs(8'h07, 20'h10001);
    meas0(16'h0000);
    outs(8'h02, 20'h10000);
    rd(7'h05, 32'h8);
    rd(7'h06, 32'h08);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    settle();
    outs(8'h00, 20'h0);
    rd(7'h05, 32'h0);
    rd(7'h06, 32'h10);
    // same clear, this time through the control register
    meas0(16'h0400);
    meas0(16'h0000);
    outs(8'h02, 20'h10000);
    wr(7'h00, 32'h1);
    settle();
    outs(8'h00, 20'h0);
    rd(7'h05, 32'h0);
    rd(7'h06, 32'h1A);
    // speed 0 to line 5, speed 1 to line 2
    wr(7'h04, 32'hAD);
    @(posedge clk_i);
    speed_i <= 2'h1;
    settle();
    chk({16'h0, spd_oe, spd_bus}, 32'h2420);
    @(posedge clk_i);
    speed_i <= 2'h2;
    settle();
    chk({16'h0, spd_oe, spd_bus}, 32'h2404);
    print_verdict();
  end
endmodule : test_channel_alarm_supervisor
`default_nettype wire
